// File: rtl/hia_device.sv
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`include "hia_params.svh"
module hia_device
  import hia_pkg::*;
#(
  // Identity value is arbitrary.
  parameter hia_byte_t ID_VALUE = 8'h5A
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  hia_if.dev bus,
  input wire logic [3:0] signal_loss_status,
  input wire logic [3:0] driver_fault_status,
  input wire logic [3:0] alarm_indication_status,
  input wire logic [3:0] loop_code_status
);
  localparam logic [4:0] STAT_ADR [`HIA_NCLS] = '{`HIA_ST0_ADR, `HIA_ST1_ADR, `HIA_ST2_ADR, `HIA_ST3_ADR};
  localparam logic [4:0] MASK_ADR [`HIA_NCLS] = '{`HIA_MK0_ADR, `HIA_MK1_ADR, `HIA_MK2_ADR, `HIA_MK3_ADR};
  localparam logic [4:0] FLAG_ADR [`HIA_NCLS] = '{`HIA_FL0_ADR, `HIA_FL1_ADR, `HIA_FL2_ADR, `HIA_FL3_ADR};
  localparam logic [3:0] CLS_EXP = `HIA_CLS_EXP;

  logic parallel;
  logic ds_proto;
  logic muxed;
  logic cs;
  logic [3:0] stat [`HIA_NCLS];
  logic [3:0] stat_prev_reg [`HIA_NCLS];
  logic [3:0] signal_loss_irq_mask;
  logic [3:0] driver_fault_irq_mask;
  logic [3:0] alarm_indication_irq_mask;
  logic [3:0] loop_code_irq_mask;
  logic [3:0] mask_reg [`HIA_NCLS];
  logic [3:0] flag_reg [`HIA_NCLS];
  logic [3:0] signal_loss_irq_flag;
  logic [3:0] driver_fault_irq_flag;
  logic [3:0] alarm_indication_irq_flag;
  logic [3:0] loop_code_irq_flag;
  hia_byte_t bank_pointer_select_reg;
  hia_byte_t prim_mem [`HIA_PRI_NUM];
  hia_byte_t exp_mem [`HIA_EXP_NUM];
  hia_byte_t rdata_reg;
  logic exp_bank;
  logic acc_act;
  logic acc_read;
  logic as_act;
  logic par_prev_reg;
  logic ack_reg;
  logic par_go;
  logic [4:0] addr_lat_reg;
  logic [4:0] par_addr;
  logic ser_on;
  logic sclk_prev_reg;
  logic ser_rise;
  logic ser_fall;
  logic [4:0] bit_cnt_reg;
  hia_byte_t cmd_reg;
  hia_byte_t sdata_reg;
  logic sdo_reg;
  logic ser_rd_go;
  logic ser_wr_go;
  logic rd_go;
  logic wr_go;
  logic [4:0] acc_addr;
  hia_byte_t acc_wdata;

  // The serial level is a mid-supply strap, seen here as the low state of the pin input.
  assign parallel = bus.iface_sel_serial_parallel;
  assign muxed = bus.iface_sel_bus_layout;
  assign ds_proto = ~bus.iface_sel_protocol;
  assign cs = ~bus.cs_n;
  assign stat[0] = signal_loss_status;
  assign stat[1] = driver_fault_status;
  assign stat[2] = alarm_indication_status;
  assign stat[3] = loop_code_status;
  assign signal_loss_irq_mask = mask_reg[0];
  assign driver_fault_irq_mask = mask_reg[1];
  assign alarm_indication_irq_mask = mask_reg[2];
  assign loop_code_irq_mask = mask_reg[3];
  assign signal_loss_irq_flag = flag_reg[0];
  assign driver_fault_irq_flag = flag_reg[1];
  assign alarm_indication_irq_flag = flag_reg[2];
  assign loop_code_irq_flag = flag_reg[3];
  assign exp_bank = (bank_pointer_select_reg == `HIA_BANK_EXP);

  function automatic logic is_special(input logic e, input logic [4:0] a);
    logic hit;
    hit = 1'h0;
    for (int k = 0; k < `HIA_NCLS; k++) begin
      if (CLS_EXP[k] == e && (a == STAT_ADR[k] || a == MASK_ADR[k] || a == FLAG_ADR[k])) begin
        hit = 1'h1;
      end
    end
    return hit;
  endfunction

  function automatic hia_byte_t rd_fn(input logic e, input logic [4:0] a);
    hia_byte_t v;
    v = 8'h00;
    if (a == `HIA_BANK_ADR) begin
      v = bank_pointer_select_reg;
    end else if (e) begin
      if (a < `HIA_TST_LO) begin
        v = exp_mem[a[3:0]];
      end
    end else if (a == `HIA_ID_ADR) begin
      v = ID_VALUE;
    end else if (a < `HIA_RSV_LO && a != `HIA_RS_ADR) begin
      v = prim_mem[a];
    end
    for (int k = 0; k < `HIA_NCLS; k++) begin
      if (CLS_EXP[k] == e) begin
        if (a == STAT_ADR[k]) begin
          v = {4'h0, stat[k]};
        end else if (a == MASK_ADR[k]) begin
          v = {4'h0, mask_reg[k]};
        end else if (a == FLAG_ADR[k]) begin
          v = {4'h0, flag_reg[k]};
        end
      end
    end
    return v;
  endfunction

  // Parallel port; strobes count only under chip select.
  assign acc_act = parallel & cs & (ds_proto ? ~bus.ds_rd_n : (~bus.ds_rd_n | ~bus.rw_wr_n));
  assign acc_read = ds_proto ? bus.rw_wr_n : ~bus.ds_rd_n;
  assign as_act = parallel & cs & (ds_proto ? ~bus.as_ale : bus.as_ale);
  assign par_go = acc_act & ~par_prev_reg;
  assign par_addr = muxed ? addr_lat_reg : bus.addr;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      addr_lat_reg <= 5'h00;
    end else if (as_act && muxed) begin
      addr_lat_reg <= bus.d_bus[4:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      par_prev_reg <= 1'h0;
      ack_reg <= 1'h0;
    end else begin
      par_prev_reg <= acc_act;
      ack_reg <= acc_act & (ack_reg | par_go);
    end
  end

  // Serial port; a frame restarts whenever chip select goes inactive.
  assign ser_on = ~parallel & cs;
  assign ser_rise = ser_on & bus.sclk & ~sclk_prev_reg;
  assign ser_fall = ser_on & ~bus.sclk & sclk_prev_reg;
  assign ser_rd_go = ser_rise & (bit_cnt_reg == `HIA_CMD_BITS - 5'h01) & cmd_reg[0];
  assign ser_wr_go = ser_rise & (bit_cnt_reg == `HIA_FRAME_BITS - 5'h01) & ~cmd_reg[0];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sclk_prev_reg <= 1'h0;
    end else begin
      sclk_prev_reg <= bus.sclk;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_reg <= 5'h00;
      cmd_reg <= 8'h00;
      sdata_reg <= 8'h00;
    end else if (!ser_on) begin
      bit_cnt_reg <= 5'h00;
    end else if (ser_rise && bit_cnt_reg < `HIA_FRAME_BITS) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      if (bit_cnt_reg < `HIA_CMD_BITS) begin
        cmd_reg[bit_cnt_reg[2:0]] <= bus.serial_in_pin;
      end else begin
        sdata_reg[bit_cnt_reg[2:0]] <= bus.serial_in_pin;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sdo_reg <= 1'h0;
    end else if (ser_fall && bit_cnt_reg >= `HIA_CMD_BITS && bit_cnt_reg < `HIA_FRAME_BITS) begin
      sdo_reg <= rdata_reg[bit_cnt_reg[2:0]];
    end
  end

  // Both ports meet in one access path.
  assign rd_go = (par_go & acc_read) | ser_rd_go;
  assign wr_go = (par_go & ~acc_read) | ser_wr_go;
  assign acc_addr = parallel ? par_addr : cmd_reg[5:1];
  assign acc_wdata = parallel ? bus.d_bus : {bus.serial_in_pin, sdata_reg[6:0]};

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 8'h00;
    end else if (rd_go) begin
      rdata_reg <= rd_fn(exp_bank, acc_addr);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bank_pointer_select_reg <= `HIA_BANK_RST;
    end else if (wr_go && acc_addr == `HIA_BANK_ADR) begin
      bank_pointer_select_reg <= acc_wdata;
    end
  end

  // Test and reserved locations hold nothing, so writes there vanish and reads give zero.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `HIA_PRI_NUM; i++) begin
        prim_mem[i] <= 8'h00;
      end
      for (int i = 0; i < `HIA_EXP_NUM; i++) begin
        exp_mem[i] <= 8'h00;
      end
    end else if (wr_go && !is_special(exp_bank, acc_addr)) begin
      if (exp_bank && acc_addr < `HIA_TST_LO) begin
        exp_mem[acc_addr[3:0]] <= acc_wdata;
      end else if (!exp_bank && acc_addr < `HIA_RSV_LO) begin
        prim_mem[acc_addr] <= acc_wdata;
      end
    end
  end

  generate
    for (genvar k = 0; k < `HIA_NCLS; k++) begin : g_cls
      logic hit_bank;
      assign hit_bank = (CLS_EXP[k] == exp_bank);
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          mask_reg[k] <= 4'h0;
        end else if (wr_go && hit_bank && acc_addr == MASK_ADR[k]) begin
          mask_reg[k] <= acc_wdata[3:0];
        end
      end
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          stat_prev_reg[k] <= 4'h0;
          flag_reg[k] <= 4'h0;
        end else begin
          stat_prev_reg[k] <= stat[k];
          // A transition in the clearing cycle survives the clear.
          flag_reg[k] <= (flag_reg[k] & ~{4{rd_go && hit_bank && acc_addr == STAT_ADR[k]}})
            | (mask_reg[k] & (stat[k] ^ stat_prev_reg[k]));
        end
      end
    end
  endgenerate

  assign bus.d_dev = rdata_reg;
  assign bus.d_dev_oe = acc_act & acc_read;
  // Acknowledge drops with the strobe, so a host never sees a stale one after it lets go.
  assign bus.ack_rdy = ds_proto ? ~(ack_reg & acc_act) : (ack_reg & acc_act);
  assign bus.int_pull = 1'h0;
  assign bus.int_oe = |{flag_reg[0], flag_reg[1], flag_reg[2], flag_reg[3]};
  assign bus.serial_out_pin = sdo_reg;
  assign bus.serial_out_oe = ser_on & cmd_reg[0] & (bit_cnt_reg >= `HIA_CMD_BITS);
endmodule

// File: rtl/hia_params.svh
// Overview of operation
// - Mid-level select pin serial, high parallel.
// - Layout pin: low separate, high multiplexed bus.
// - Protocol pin: low data strobe, high read/write strobes.
// - Select codes 100,101,110,111 pick parallel variants.
// - Exactly five address bits decoded, upper ignored.
// - Separate mode: five address lines, eight data.
// - Multiplexed: low five bus bits latched address.
// - Serial frame: command byte then data byte.
// - Command: direction bit, address bits one-five.
// - Direction one reads out, zero writes in.
// - Four status classes share one interrupt output.
// - Masked status transition sets flag, asserts interrupt.
// - Masks reset zero; zero mask ignores transitions.
// - Interrupt output only pulls low, wired-OR.
// - Reading live status clears its interrupt flags.
// - Live status follows condition, clears itself.
// - Interrupt released only when nothing pending.
// - Bank pointer at address 1F, both banks.
// - AAH selects expanded bank, clearing selects primary.
// - Twenty-three primary plus sixteen expanded registers.
// - Host writes reserved bits with default values.
`ifndef HIA_PARAMS_SVH
`define HIA_PARAMS_SVH
`define HIA_AW 5
`define HIA_DW 8
`define HIA_NCH 4
`define HIA_NCLS 4
`define HIA_BANK_ADR 5'h1F
`define HIA_BANK_EXP 8'hAA
`define HIA_BANK_RST 8'h00
`define HIA_ID_ADR 5'h00
`define HIA_RS_ADR 5'h0A
`define HIA_RSV_LO 5'h16
`define HIA_TST_LO 5'h10
`define HIA_EXP_NUM 16
`define HIA_PRI_NUM 32
`define HIA_ST0_ADR 5'h04
`define HIA_ST1_ADR 5'h05
`define HIA_MK0_ADR 5'h06
`define HIA_MK1_ADR 5'h07
`define HIA_FL0_ADR 5'h08
`define HIA_FL1_ADR 5'h09
`define HIA_ST2_ADR 5'h13
`define HIA_MK2_ADR 5'h14
`define HIA_FL2_ADR 5'h15
`define HIA_ST3_ADR 5'h0B
`define HIA_MK3_ADR 5'h0C
`define HIA_FL3_ADR 5'h0D
`define HIA_CLS_EXP 4'h8
`define HIA_CMD_BITS 5'h08
`define HIA_FRAME_BITS 5'h10
`define HIA_H_CMD 2'h0
`define HIA_H_STAT 2'h1
`define HIA_H_MODE 2'h2
`define HIA_MODE_RST 3'h4
`endif

// File: rtl/hia_pkg.sv
package hia_pkg;
  typedef logic [7:0] hia_byte_t;
  typedef enum logic [2:0] {HS_IDLE, HS_ADDR, HS_HOLD, HS_STRB, HS_DONE, HS_SER} hia_hstate_e;
endpackage

// File: rtl/hia_if.sv
`timescale 1ns/10ps
interface hia_if;
  logic iface_sel_serial_parallel;
  logic iface_sel_bus_layout;
  logic iface_sel_protocol;
  logic cs_n;
  logic [4:0] addr;
  logic [7:0] d_host;
  logic d_host_oe;
  logic [7:0] d_dev;
  logic d_dev_oe;
  logic [7:0] d_bus;
  logic ds_rd_n;
  logic rw_wr_n;
  logic as_ale;
  logic ack_rdy;
  logic int_pull;
  logic int_oe;
  logic int_line_n;
  logic sclk;
  logic serial_in_pin;
  logic serial_out_pin;
  logic serial_out_oe;
  logic sdo_line;
  // An undriven shared line reads as its pull-up.
  assign d_bus = d_dev_oe ? d_dev : (d_host_oe ? d_host : 8'hFF);
  assign int_line_n = int_oe ? int_pull : 1'h1;
  assign sdo_line = serial_out_oe ? serial_out_pin : 1'h1;
  modport dev (input iface_sel_serial_parallel, input iface_sel_bus_layout, input iface_sel_protocol,
    input cs_n, input addr, input d_bus, output d_dev, output d_dev_oe, input ds_rd_n, input rw_wr_n,
    input as_ale, output ack_rdy, output int_pull, output int_oe, input sclk, input serial_in_pin,
    output serial_out_pin, output serial_out_oe);
  modport host (output iface_sel_serial_parallel, output iface_sel_bus_layout, output iface_sel_protocol,
    output cs_n, output addr, output d_host, output d_host_oe, input d_bus, output ds_rd_n, output rw_wr_n,
    output as_ale, input ack_rdy, input int_line_n, output sclk, output serial_in_pin, input sdo_line);
endinterface

// File: rtl/hia_host.sv
`timescale 1ns/10ps
`include "hia_params.svh"
module hia_host
  import hia_pkg::*;
#(
  parameter int PHASE_CYC = 4
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  hia_if.host bus,
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata
);
  localparam logic [7:0] PH_LAST = 8'(PHASE_CYC - 1);

  hia_hstate_e state_reg;
  logic [2:0] mode_reg;
  logic [7:0] cnt_reg;
  logic [4:0] addr_reg;
  logic rw_reg;
  hia_byte_t wd_reg;
  hia_byte_t rd_data_reg;
  logic [15:0] frame_reg;
  logic [4:0] bit_reg;
  logic sclk_reg;
  logic ds_proto;
  logic muxed;
  logic ph_end;
  logic acked;
  logic start;

  assign ds_proto = ~mode_reg[0];
  assign muxed = mode_reg[1];
  assign ph_end = (cnt_reg == PH_LAST);
  assign acked = ds_proto ? ~bus.ack_rdy : bus.ack_rdy;
  assign start = reg_wr && reg_addr == `HIA_H_CMD && state_reg == HS_IDLE;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= `HIA_MODE_RST;
    end else if (reg_wr && reg_addr == `HIA_H_MODE) begin
      mode_reg <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      addr_reg <= 5'h00;
      rw_reg <= 1'h0;
      wd_reg <= 8'h00;
    end else if (start) begin
      addr_reg <= reg_wdata[4:0];
      rw_reg <= reg_wdata[5];
      wd_reg <= reg_wdata[15:8];
    end
  end

  // Each pin phase except the strobe, which holds until acknowledge, lasts PHASE_CYC clocks so the device sees every level at least twice.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= HS_IDLE;
      cnt_reg <= 8'h00;
      bit_reg <= 5'h00;
      sclk_reg <= 1'h0;
      frame_reg <= 16'h0000;
      rd_data_reg <= 8'h00;
    end else begin
      cnt_reg <= ph_end ? 8'h00 : cnt_reg + 8'h01;
      unique case (state_reg)
        HS_IDLE: begin
          cnt_reg <= 8'h00;
          bit_reg <= 5'h00;
          sclk_reg <= 1'h0;
          if (start) begin
            frame_reg <= {reg_wdata[15:8], 2'h0, reg_wdata[4:0], reg_wdata[5]};
            state_reg <= mode_reg[2] ? HS_ADDR : HS_SER;
          end
        end
        HS_ADDR: begin
          if (ph_end) begin
            state_reg <= HS_HOLD;
          end
        end
        HS_HOLD: begin
          if (ph_end) begin
            state_reg <= HS_STRB;
          end
        end
        HS_STRB: begin
          cnt_reg <= 8'h00;
          if (acked) begin
            rd_data_reg <= bus.d_bus;
            state_reg <= HS_DONE;
          end
        end
        HS_DONE: begin
          if (ph_end) begin
            state_reg <= HS_IDLE;
          end
        end
        HS_SER: begin
          if (ph_end) begin
            sclk_reg <= ~sclk_reg;
            if (!sclk_reg && bit_reg >= `HIA_CMD_BITS) begin
              rd_data_reg <= {bus.sdo_line, rd_data_reg[7:1]};
            end
            if (sclk_reg) begin
              bit_reg <= bit_reg + 5'h01;
              frame_reg <= {1'h0, frame_reg[15:1]};
              if (bit_reg == `HIA_FRAME_BITS - 5'h01) begin
                state_reg <= HS_DONE;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `HIA_H_STAT: reg_rdata <= {rd_data_reg, 6'h00, ~bus.int_line_n, state_reg != HS_IDLE};
        `HIA_H_MODE: reg_rdata <= {13'h0000, mode_reg};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  assign bus.iface_sel_serial_parallel = mode_reg[2];
  assign bus.iface_sel_bus_layout = mode_reg[1];
  assign bus.iface_sel_protocol = mode_reg[0];
  assign bus.cs_n = (state_reg == HS_IDLE) || (state_reg == HS_DONE);
  assign bus.addr = addr_reg;
  assign bus.as_ale = ds_proto ? (state_reg != HS_ADDR) : (state_reg == HS_ADDR);
  // Reserved bits are the caller's to fill with their defaults.
  assign bus.d_host = (state_reg == HS_ADDR) ? {3'h0, addr_reg} : wd_reg;
  assign bus.d_host_oe = (muxed && state_reg == HS_ADDR)
    || (!rw_reg && (state_reg == HS_HOLD || state_reg == HS_STRB));
  assign bus.ds_rd_n = ~((state_reg == HS_STRB) && (ds_proto || rw_reg));
  assign bus.rw_wr_n = ds_proto ? rw_reg : ~((state_reg == HS_STRB) && !rw_reg);
  assign bus.sclk = sclk_reg;
  assign bus.serial_in_pin = frame_reg[0];
endmodule

// File: verif/hia_chk.sv
`timescale 1ns/10ps
module hia_chk (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic iface_sel_serial_parallel,
  input wire logic iface_sel_bus_layout,
  input wire logic iface_sel_protocol,
  input wire logic cs_n,
  input wire logic ds_rd_n,
  input wire logic rw_wr_n,
  input wire logic as_ale,
  input wire logic d_host_oe,
  input wire logic d_dev_oe,
  input wire logic ack_rdy,
  input wire logic int_pull,
  input wire logic int_oe,
  input wire logic sclk,
  input wire logic serial_out_oe
);
  logic sclk_d;
  logic [4:0] rise_cnt;
  logic strb_idle;
  logic as_on;
  assign strb_idle = iface_sel_protocol ? (ds_rd_n && rw_wr_n) : ds_rd_n;
  assign as_on = iface_sel_protocol ? as_ale : !as_ale;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Saturating count of link clock rises in a frame, so stray clocks cannot wrap it.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sclk_d <= 1'b0;
      rise_cnt <= 5'h00;
    end else begin
      sclk_d <= sclk;
      if (cs_n) begin
        rise_cnt <= 5'h00;
      end else if (sclk && !sclk_d && rise_cnt != 5'h1F) begin
        rise_cnt <= rise_cnt + 5'h01;
      end
    end
  end
  a_drive_on_read: assert property (d_dev_oe |-> !cs_n && !ds_rd_n && rw_wr_n)
    else $error("Device drives data outside a read.");
  a_sdo_mode_only: assert property (serial_out_oe |-> !iface_sel_serial_parallel)
    else $error("Serial output driven in parallel mode.");
  a_sdo_after_cmd: assert property (serial_out_oe |-> !cs_n && rise_cnt >= 5'h08)
    else $error("Serial output driven before the command byte ends.");
  a_int_pull_low: assert property (int_oe |-> !int_pull)
    else $error("Interrupt output drives a high level.");
  a_ack_release: assert property (iface_sel_serial_parallel && (cs_n || strb_idle) |-> ack_rdy == !iface_sel_protocol)
    else $error("Acknowledge active without a selected strobe.");
  a_ack_latency: assert property (iface_sel_serial_parallel && !cs_n && $fell(strb_idle)
    |-> ##[1:2] ack_rdy == iface_sel_protocol)
    else $error("Acknowledge late after strobe.");
  a_mux_addr_phase: assert property (iface_sel_serial_parallel && iface_sel_bus_layout && !cs_n && as_on
    |-> d_host_oe && !d_dev_oe)
    else $error("Address phase without host drive.");
  a_frame_len: assert property ($rose(cs_n) && !iface_sel_serial_parallel |-> rise_cnt == 5'h10)
    else $error("Serial frame is not sixteen clocks.");
  a_sclk_idle: assert property ($fell(cs_n) |-> !sclk)
    else $error("Link clock not idle low at frame start.");
endmodule

// File: verif/host_register_access_and_irq_bench.sv
`timescale 1ns/10ps
module host_register_access_and_irq_bench;
  import hia_pkg::*;
  // The identity value is arbitrary.
  localparam hia_byte_t ID_EXP = 8'h5A;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] st = 16'h0000;
  logic [15:0] rd_v;
  hia_byte_t rv;
  int num_errors = 0;
  int n_tests = 0;
  logic [2:0] modes [5] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
  logic [4:0] a_st [4] = '{5'h04, 5'h05, 5'h13, 5'h0B};
  logic [4:0] a_mk [4] = '{5'h06, 5'h07, 5'h14, 5'h0C};
  logic [4:0] a_fl [4] = '{5'h08, 5'h09, 5'h15, 5'h0D};
  hia_if bus_if();
  hia_device #(.ID_VALUE(ID_EXP)) hia_device_inst (.clk_sys(clk_sys), .arst_n(arst_n), .bus(bus_if),
    .signal_loss_status(st[3:0]), .driver_fault_status(st[7:4]), .alarm_indication_status(st[11:8]),
    .loop_code_status(st[15:12]));
  hia_host #(.PHASE_CYC(4)) hia_host_inst (.clk_sys(clk_sys), .arst_n(arst_n), .bus(bus_if),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  hia_chk hia_chk_inst (.clk_sys(clk_sys), .arst_n(arst_n),
    .iface_sel_serial_parallel(bus_if.iface_sel_serial_parallel), .iface_sel_bus_layout(bus_if.iface_sel_bus_layout),
    .iface_sel_protocol(bus_if.iface_sel_protocol), .cs_n(bus_if.cs_n), .ds_rd_n(bus_if.ds_rd_n),
    .rw_wr_n(bus_if.rw_wr_n), .as_ale(bus_if.as_ale), .d_host_oe(bus_if.d_host_oe), .d_dev_oe(bus_if.d_dev_oe),
    .ack_rdy(bus_if.ack_rdy), .int_pull(bus_if.int_pull), .int_oe(bus_if.int_oe), .sclk(bus_if.sclk),
    .serial_out_oe(bus_if.serial_out_oe));
  always #25 clk_sys = ~clk_sys;
  task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task sw_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task sw_rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Polling is bounded so a stuck link shows up as a mismatch, not a hang.
  task dev_acc(input logic [4:0] a, input logic rd, input hia_byte_t wd);
    int k;
    sw_wr(2'h0, {wd, 2'h0, rd, a});
    for (k = 0; k < 400; k++) begin
      sw_rd(2'h1, rd_v);
      if (rd_v[0] === 1'b0) break;
    end
    if (k == 400) check(16'h0001, 16'h0000, "busy");
    rv = rd_v[15:8];
  endtask
  task wr8(input logic [4:0] a, input hia_byte_t d);
    dev_acc(a, 1'b0, d);
  endtask
  task rd8(input logic [4:0] a, input hia_byte_t e, input string what);
    dev_acc(a, 1'b1, 8'h00);
    check({8'h00, rv}, {8'h00, e}, what);
  endtask
  task int_chk(input logic e);
    sw_rd(2'h1, rd_v);
    check({15'h0000, rd_v[1]}, {15'h0000, e}, "int_low");
    check({15'h0000, bus_if.int_line_n}, {15'h0000, !e}, "int_line_n");
  endtask
  task wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task end_sim();
    $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    wait_cyc(20000);
    num_errors++;
    $display("Error watchdog expected done seen running");
    end_sim();
  end
  initial begin
    int m;
    int c;
    hia_byte_t pv;
    wait_cyc(12);
    arst_n <= 1'b1;
    for (m = 0; m < 5; m++) begin
      sw_wr(2'h2, {13'h0000, modes[m]});
      rd8(5'h00, ID_EXP, "id");
      pv = 8'hA0 + 8'(m);
      wr8(5'h01, pv);
      rd8(5'h01, pv, "rw_reg");
      rd8(5'h1F, 8'h00, "bank_rst");
    end
    sw_wr(2'h2, 16'h0007);
    rd8(5'h06, 8'h00, "mask_rst");
    wr8(5'h16, 8'hFF);
    rd8(5'h16, 8'h00, "reserved");
    wr8(5'h1F, 8'hAA);
    rd8(5'h1F, 8'hAA, "bank_exp");
    wr8(5'h01, 8'h3C);
    wr8(5'h1F, 8'hAB);
    rd8(5'h01, pv, "bank_near");
    wr8(5'h1F, 8'hAA);
    rd8(5'h01, 8'h3C, "exp_reg");
    wr8(5'h1F, 8'h00);
    rd8(5'h01, pv, "pri_reg");
    for (c = 0; c < 4; c++) begin
      if (c == 3) wr8(5'h1F, 8'hAA);
      @(posedge clk_sys);
      st[c*4+1] <= 1'b1;
      wait_cyc(3);
      rd8(a_fl[c], 8'h00, "flag_masked");
      int_chk(1'b0);
      wr8(a_mk[c], 8'h0F);
      @(posedge clk_sys);
      st[c*4] <= 1'b1;
      wait_cyc(3);
      rd8(a_fl[c], 8'h01, "flag_rise");
      int_chk(1'b1);
      rd8(a_st[c], 8'h03, "status_live");
      rd8(a_fl[c], 8'h00, "flag_clear");
      int_chk(1'b0);
      @(posedge clk_sys);
      st[c*4 +: 2] <= 2'h0;
      wait_cyc(3);
      rd8(a_fl[c], 8'h03, "flag_fall");
      rd8(a_st[c], 8'h00, "status_gone");
      rd8(a_fl[c], 8'h00, "flag_clear2");
      wr8(a_mk[c], 8'h00);
      if (c == 3) wr8(5'h1F, 8'h00);
    end
    wr8(5'h06, 8'h0F);
    wr8(5'h07, 8'h0F);
    @(posedge clk_sys);
    st[4] <= 1'b1;
    st[0] <= 1'b1;
    wait_cyc(3);
    rd8(5'h04, 8'h01, "loss_live");
    int_chk(1'b1);
    rd8(5'h05, 8'h01, "fault_live");
    int_chk(1'b0);
    end_sim();
  end
endmodule
